//--- rtl/lpmc_delay_line.sv
// Fixed-depth shift line that times the first read beat.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module lpmc_delay_line #(
  parameter int DEPTH = 3
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             pulseIn,
  input  wire logic [1:0]       tapSel,
  output logic                  pulseOut
);
  logic [DEPTH-1:0] stage_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage_r <= '0;
    end else begin
      stage_r <= {stage_r[DEPTH-2:0], pulseIn};
    end
  end

  // Registered tap keeps the output glitch free
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pulseOut <= 1'b0;
    end else begin
      pulseOut <= (tapSel == 2'h1) ? stage_r[0] : stage_r[1];
    end
  end
endmodule

//--- rtl/lpmc_mode_config.sv
// Mode configuration and burst column ordering of a low-power DDR memory.
// Assumes commands are decoded upstream and sampled on the rising clk.
// Operation
// - Base mode load with both bank bits low
// - Base bits 0-2 select burst length
// - Base bit 3 selects sequential or interleaved
// - Base bits 4-6 select read latency
// - First read data after latency cycles
// - Extended load with high bank bit set and low bank bit clear
// - Extended fields: partial, temperature, drive strength
// - Partial refresh limits retained array portion
// - Refresh settings act only in self-refresh
// - Internal compensation ignores temperature bits
// - Drive field selects full, half, quarter, three-quarter
// - Upper column bits select aligned burst block
// - Burst wraps inside its block
// - Sequential adds, interleaved XORs beat index
// - Burst length same for reads and writes
// - Mode loads sampled on rising clock edge
`timescale 1ns/1ps
module lpmc_mode_config #(
  parameter bit INTERNAL_TEMP = 1'b0,
  parameter bit HAS_BL16      = 1'b1
) (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          modeLoad,
  input  wire logic [1:0]                    bankSelect,
  input  wire logic [lpmc_pkg::ADDR_W-1:0]   addr,
  input  wire logic                          deepSleep,
  input  wire logic                          selfRefresh,
  input  wire logic                          readCmd,
  input  wire logic                          writeCmd,
  input  wire logic [lpmc_pkg::COL_W-1:0]    startCol,
  output lpmc_pkg::lpmc_base_s               baseCfg,
  output lpmc_pkg::lpmc_ext_s                extCfg,
  output logic                               cfgValid,
  output logic [2:0]                         activePartial,
  output logic [1:0]                         activeTemp,
  output logic [4:0]                         burstBeats,
  output lpmc_pkg::lpmc_col_s                colOut,
  output logic                               firstReadData
);
  typedef enum {ST_IDLE, ST_BURST} lpmc_state_e;

  lpmc_state_e                    state_r;
  lpmc_state_e                    state_nxt;
  logic [lpmc_pkg::ADDR_W-1:0]    base_r;
  logic [lpmc_pkg::ADDR_W-1:0]    ext_r;
  logic                           baseOk_r;
  logic                           extOk_r;
  logic [3:0]                     beat_r;
  logic [3:0]                     beat_nxt;
  logic [3:0]                     offset_r;
  logic [lpmc_pkg::COL_W-1:0]     block_r;
  logic [3:0]                     mask_r;
  logic                           inter_r;
  logic                           isWr_r;
  logic                           loadBase;
  logic                           loadExt;
  logic [3:0]                     curMask;
  logic [3:0]                     ordered;
  logic                           startBurst;
  logic                           lastBeat;
  logic [1:0]                     extTemp;
  logic [1:0]                     latTap;

  // All checks below run on the command clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Beat mask from a length code; unknown codes fall back to two beats
  function automatic logic [3:0] lenMask(input logic [2:0] code);
    logic [3:0] m;
    m = 4'h1;
    if (code == lpmc_pkg::BL4) m = 4'h3;
    if (code == lpmc_pkg::BL8) m = 4'h7;
    if (code == lpmc_pkg::BL16 && HAS_BL16) m = 4'hf;
    return m;
  endfunction

  // Column within block for a given beat
  function automatic logic [3:0] beatCol(input logic [3:0] off,
                                         input logic [3:0] beat,
                                         input logic [3:0] m,
                                         input logic       inter);
    logic [3:0] s;
    s = inter ? (off ^ beat) : 4'(off + beat);
    return s & m;
  endfunction

  // Load decode on the sampled rising edge
  assign loadBase = modeLoad && bankSelect == lpmc_pkg::BANK_BASE;
  assign loadExt  = modeLoad && bankSelect == lpmc_pkg::BANK_EXT;
  // Bank code 01 matches neither decode and is dropped

  // Internal compensation keeps the stored temperature field untouched
  assign extTemp = INTERNAL_TEMP ? ext_r[lpmc_pkg::TRS_LSB +: 2]
                                 : addr[lpmc_pkg::TRS_LSB +: 2];

  always_ff @(posedge clk) begin
    if (!reset_n || deepSleep) begin
      base_r   <= lpmc_pkg::REG_UNDEF;
      baseOk_r <= 1'b0;
    end else if (loadBase) begin
      base_r   <= addr;
      baseOk_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || deepSleep) begin
      ext_r   <= lpmc_pkg::REG_UNDEF;
      extOk_r <= 1'b0;
    end else if (loadExt) begin
      ext_r   <= {addr[12:5], extTemp, addr[2:0]};
      extOk_r <= 1'b1;
    end
  end

  // Field split of both registers
  assign baseCfg.burstLen  = base_r[lpmc_pkg::BL_LSB +: 3];
  assign baseCfg.burstType = base_r[lpmc_pkg::BT_BIT];
  assign baseCfg.latency   = base_r[lpmc_pkg::CL_LSB +: 3];
  assign extCfg.partialArray  = ext_r[lpmc_pkg::PAR_LSB +: 3];
  assign extCfg.tempRefresh   = ext_r[lpmc_pkg::TRS_LSB +: 2];
  assign extCfg.driveStrength = ext_r[lpmc_pkg::DRV_LSB +: 3];
  assign cfgValid = baseOk_r && extOk_r;

  // Refresh settings reach the array only in self-refresh
  assign activePartial = selfRefresh ? extCfg.partialArray
                                     : lpmc_pkg::PAR_FULL;
  assign activeTemp    = selfRefresh ? extCfg.tempRefresh : 2'h0;

  assign curMask    = lenMask(baseCfg.burstLen);
  assign burstBeats = 5'(curMask) + 5'h1;

  // Burst walker; same length for reads and writes
  assign startBurst = readCmd || writeCmd;
  assign lastBeat   = beat_r == mask_r;
  assign ordered    = beatCol(offset_r, beat_r, mask_r, inter_r);

  always_comb begin
    state_nxt = state_r;
    beat_nxt  = beat_r;
    unique case (state_r)
      ST_IDLE: begin
        beat_nxt = 4'h0;
        if (startBurst) state_nxt = ST_BURST;
      end
      ST_BURST: begin
        beat_nxt = 4'(beat_r + 4'h1);
        if (lastBeat && !startBurst) begin
          state_nxt = ST_IDLE;
        end
        if (lastBeat) beat_nxt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      beat_r  <= 4'h0;
    end else begin
      state_r <= state_nxt;
      beat_r  <= beat_nxt;
    end
  end

  // A new command is only taken at the end of a burst or while idle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      offset_r <= 4'h0;
      block_r  <= '0;
      mask_r   <= 4'h1;
      inter_r  <= 1'b0;
      isWr_r   <= 1'b0;
    end else if (startBurst && (state_r == ST_IDLE || lastBeat)) begin
      mask_r   <= curMask;
      offset_r <= startCol[3:0] & curMask;
      block_r  <= startCol & ~{{(lpmc_pkg::COL_W-4){1'b0}}, curMask};
      inter_r  <= baseCfg.burstType;
      isWr_r   <= writeCmd;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      colOut <= '0;
    end else begin
      colOut.valid   <= state_r == ST_BURST;
      colOut.isWrite <= isWr_r;
      colOut.col     <= block_r
                        | {{(lpmc_pkg::COL_W-4){1'b0}}, ordered};
    end
  end

  // Read latency timing: pulse after latency cycles
  // Undefined latency codes take the recommended three cycles
  assign latTap = (baseCfg.latency == lpmc_pkg::CL2) ? 2'h1 : 2'h2;

  // Two stages cover both taps, so no stage is left unread
  lpmc_delay_line #(
    .DEPTH (2)
  ) uDelay (
    .clk      (clk),
    .reset_n  (reset_n),
    .pulseIn  (readCmd),
    .tapSel   (latTap),
    .pulseOut (firstReadData)
  );

  a_base_load: assert property (
    loadBase && !deepSleep |=> base_r == $past(addr))
    else $error("base register not loaded");

  a_base_type: assert property (
    loadBase && !deepSleep |=> baseCfg.burstType == $past(addr[3]))
    else $error("burst type not loaded");

  a_base_lat: assert property (
    loadBase && !deepSleep |=> baseCfg.latency == $past(addr[6:4]))
    else $error("latency not loaded");

  a_ext_keep: assert property (
    loadBase && !deepSleep |=> $stable(ext_r))
    else $error("base load disturbed extended register");

  a_ext_drive: assert property (
    loadExt && !deepSleep |=> extCfg.driveStrength == $past(addr[7:5]))
    else $error("drive field not loaded");

  a_ext_partial: assert property (
    loadExt && !deepSleep |=> extCfg.partialArray == $past(addr[2:0]))
    else $error("partial field not loaded");

  // Internal compensation must keep the old temperature bits
  a_temp_field: assert property (
    loadExt && !deepSleep |=> extCfg.tempRefresh ==
      (INTERNAL_TEMP ? $past(extCfg.tempRefresh) : $past(addr[4:3])))
    else $error("temperature field wrong after load");

  // Both bank codes with the low bit set are reserved
  a_reserved_bank: assert property (
    modeLoad && bankSelect[0] && !deepSleep
      |=> $stable(base_r) && $stable(ext_r))
    else $error("reserved bank changed a register");

  a_refresh_gate: assert property (
    !selfRefresh |-> activePartial == lpmc_pkg::PAR_FULL
                     && activeTemp == 2'h0)
    else $error("refresh setting active outside self-refresh");

  a_refresh_pass: assert property (
    selfRefresh |-> activePartial == extCfg.partialArray)
    else $error("partial setting not applied in self-refresh");

  a_len_decode: assert property (
    baseCfg.burstLen == lpmc_pkg::BL8 |-> burstBeats == 5'h08)
    else $error("burst length eight not decoded");

  a_lat_three: assert property (
    readCmd && baseCfg.latency == lpmc_pkg::CL3 && $stable(base_r)
      |-> ##3 firstReadData)
    else $error("latency three first data late");

  a_lat_two: assert property (
    readCmd && baseCfg.latency == lpmc_pkg::CL2 && $stable(base_r)
      |-> ##2 firstReadData)
    else $error("latency two first data late");

  // Take points: idle, or the last beat for gapless bursts
  sequence s_burst_take;
    startBurst && (state_r == ST_IDLE || lastBeat);
  endsequence

  // First beat lands on the start column two cycles later
  sequence s_first_beat;
    ##2 (colOut.valid && colOut.col == $past(startCol, 2));
  endsequence

  // First beat carries the direction of its command
  sequence s_first_dir;
    ##2 (colOut.valid && colOut.isWrite == $past(writeCmd, 2));
  endsequence

  a_first_col: assert property (
    s_burst_take |-> s_first_beat)
    else $error("first beat not on start column");

  a_first_dir: assert property (
    s_burst_take |-> s_first_dir)
    else $error("burst direction lost");

  // Registered column lags the walker, so compare with last cycle
  a_block_wrap: assert property (
    colOut.valid |-> (colOut.col & ~{5'h00, $past(mask_r)})
                     == $past(block_r))
    else $error("burst left its block");

  a_sleep_clear: assert property (
    deepSleep |=> !cfgValid && base_r == lpmc_pkg::REG_UNDEF)
    else $error("config still valid after deep sleep");
endmodule

//--- rtl/lpmc_pkg.sv
// Package for the low-power DDR mode configuration block.
// Assumes a single command clock.
package lpmc_pkg;
  localparam int ADDR_W        = 13;
  localparam int COL_W         = 9;
  localparam int BL_LSB        = 0;
  localparam int BT_BIT        = 3;
  localparam int CL_LSB        = 4;
  localparam int PAR_LSB       = 0;
  localparam int TRS_LSB       = 3;
  localparam int DRV_LSB       = 5;
  localparam logic [2:0] BL2   = 3'h1;
  localparam logic [2:0] BL4   = 3'h2;
  localparam logic [2:0] BL8   = 3'h3;
  localparam logic [2:0] BL16  = 3'h4;
  localparam logic [2:0] CL2   = 3'h2;
  localparam logic [2:0] CL3   = 3'h3;
  localparam logic [2:0] PAR_FULL    = 3'h0;
  localparam logic [2:0] PAR_HALF    = 3'h1;
  localparam logic [2:0] PAR_QUARTER = 3'h2;
  localparam logic [2:0] PAR_EIGHTH  = 3'h5;
  localparam logic [2:0] PAR_SIXTEEN = 3'h6;
  localparam logic [2:0] DRV_FULL    = 3'h0;
  localparam logic [2:0] DRV_HALF    = 3'h1;
  localparam logic [2:0] DRV_QUARTER = 3'h2;
  localparam logic [2:0] DRV_THREEQ  = 3'h4;
  localparam logic [1:0] BANK_BASE   = 2'h0;
  localparam logic [1:0] BANK_EXT    = 2'h2;
  localparam logic [ADDR_W-1:0] REG_UNDEF = 13'h0000;

  typedef struct packed {
    logic       burstType;
    logic [2:0] latency;
    logic [2:0] burstLen;
  } lpmc_base_s;

  typedef struct packed {
    logic [2:0] driveStrength;
    logic [1:0] tempRefresh;
    logic [2:0] partialArray;
  } lpmc_ext_s;

  typedef struct packed {
    logic             valid;
    logic             isWrite;
    logic [COL_W-1:0] col;
  } lpmc_col_s;
endpackage

//--- testbench/lpmc_ctl_model.sv
// Controller model driving mode loads and burst commands.
// Assumes the bench calls its tasks only after reset release.
`timescale 1ns/1ps
module lpmc_ctl_model #(
  parameter int MRD = 2
) (
  input  wire logic               clk,
  output logic                    modeLoad,
  output logic [1:0]              bankSelect,
  output logic [12:0]             addr,
  output logic                    readCmd,
  output logic                    writeCmd,
  output logic [8:0]              startCol
);
  initial begin
    modeLoad = 1'b0;
    bankSelect = 2'h1;
    addr = 13'h1555;
    readCmd = 1'b0;
    writeCmd = 1'b0;
    startCol = 9'h0aa;
  end

  // Idle pins scrambled so stale values never look valid
  task automatic load(input logic [1:0] bank, input logic [12:0] op);
    @(negedge clk);
    modeLoad = 1'b1;
    bankSelect = bank;
    addr = op; // Caller zeroes undefined bits
    @(negedge clk);
    modeLoad = 1'b0;
    bankSelect = ~bank;
    addr = ~op;
    repeat (MRD) @(negedge clk); // Recovery wait, no burst in flight
  endtask

  task automatic burst(input logic wr, input logic [8:0] col);
    @(negedge clk);
    readCmd = ~wr;
    writeCmd = wr;
    startCol = col;
    @(negedge clk);
    readCmd = 1'b0;
    writeCmd = 1'b0;
    startCol = ~col;
  endtask
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the mode configuration block.
// Assumes the controller model drives every command input.
`timescale 1ns/1ps
module testbench;
  logic                 clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 deepSleep = 1'b0;
  logic                 selfRefresh = 1'b0;
  logic                 modeLoad, readCmd, writeCmd, cfgValid, firstReadData;
  logic [1:0]           bankSelect, activeTemp;
  logic [12:0]          addr;
  logic [8:0]           startCol;
  logic [2:0]           activePartial;
  logic [4:0]           burstBeats;
  lpmc_pkg::lpmc_base_s baseCfg;
  lpmc_pkg::lpmc_ext_s  extCfg;
  lpmc_pkg::lpmc_col_s  colOut;
  int                   errors = 0;
  int                   num_checks = 0;
  int                   cycles = 0;

  always #50 clk = ~clk;

  lpmc_ctl_model lpmc_ctl_model_inst (.clk(clk), .modeLoad(modeLoad),
    .bankSelect(bankSelect), .addr(addr), .readCmd(readCmd),
    .writeCmd(writeCmd), .startCol(startCol));

  lpmc_mode_config lpmc_mode_config_inst (.clk(clk), .reset_n(reset_n),
    .modeLoad(modeLoad), .bankSelect(bankSelect), .addr(addr),
    .deepSleep(deepSleep), .selfRefresh(selfRefresh), .readCmd(readCmd),
    .writeCmd(writeCmd), .startCol(startCol), .baseCfg(baseCfg),
    .extCfg(extCfg), .cfgValid(cfgValid), .activePartial(activePartial),
    .activeTemp(activeTemp), .burstBeats(burstBeats), .colOut(colOut),
    .firstReadData(firstReadData));

  function automatic int blen(input logic [2:0] code);
    return (code >= 3'h1 && code <= 3'h4) ? (1 << code) : 2;
  endfunction

  function automatic logic [8:0] expCol(input logic [8:0] c, input int n,
                                        input logic bt, input int b);
    logic [8:0] m;
    m = 9'(n - 1);
    return (c & ~m) | ((bt ? (c ^ 9'(b)) : (c + 9'(b))) & m);
  endfunction

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Whole run is under 650 cycles; ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("MISMATCH t=%0t timeout", $time);
      wrap_up();
    end
  end

  task automatic run(input logic wr, input logic [8:0] col,
                     input logic [2:0] bl, input logic bt,
                     input logic [2:0] cl);
    int n;
    int fr;
    n = blen(bl);
    fr = -1;
    check(burstBeats === 5'(n), "len");
    lpmc_ctl_model_inst.burst(wr, col);
    for (int j = 2; j < n + 4; j++) begin
      @(negedge clk);
      if (firstReadData === 1'b1) fr = j;
      if (j < n + 2) begin
        check(colOut === {1'b1, wr, expCol(col, n, bt, j - 2)}, "col");
      end
    end
    check(colOut.valid === 1'b0, "wrap");
    check(fr === (wr ? -1 : (cl == 3'h2 ? 2 : 3)), "lat");
  endtask

  initial begin
    logic [2:0]           bl, cl, par, drv;
    logic [1:0]           tmp;
    logic                 bt;
    lpmc_pkg::lpmc_base_s b;
    lpmc_pkg::lpmc_ext_s  e;
    void'($urandom(98));
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    b = {1'b0, 3'h3, 3'h2};
    lpmc_ctl_model_inst.load(2'h0, 13'h0032);
    check(baseCfg === b && cfgValid === 1'b0, "base");
    for (int i = 0; i < 5; i++) begin
      par = (i < 3) ? 3'(i) : 3'(i + 2);
      drv = (i == 3) ? 3'h4 : 3'(i % 4);
      tmp = 2'($urandom);
      e = {drv, tmp, par};
      lpmc_ctl_model_inst.load(2'h2, {5'h0, drv, tmp, par});
      check(extCfg === e, "ext");
      check(activePartial === 3'h0 && activeTemp === 2'h0, "idle");
      selfRefresh = 1'b1;
      @(negedge clk);
      check(activePartial === par && activeTemp === tmp, "sr");
      selfRefresh = 1'b0;
    end
    check(cfgValid === 1'b1, "valid");
    lpmc_ctl_model_inst.load(2'h1, 13'h1fff);
    lpmc_ctl_model_inst.load(2'h3, 13'h0000);
    check(baseCfg === b && extCfg === e, "reserved");
    // First pass is the worst wrap case: top column, longest burst
    for (int i = 0; i < 24; i++) begin
      bl = (i == 0) ? lpmc_pkg::BL16 : 3'($urandom_range(1, 4));
      bt = (i == 0) ? 1'b1 : 1'($urandom);
      cl = $urandom_range(0, 1) ? lpmc_pkg::CL2 : lpmc_pkg::CL3;
      b = {bt, cl, bl};
      lpmc_ctl_model_inst.load(2'h0, {6'h0, cl, bt, bl});
      check(baseCfg === b, "base");
      run(1'($urandom), (i == 0) ? 9'h1ff : 9'($urandom), bl, bt, cl);
    end
    deepSleep = 1'b1;
    @(negedge clk);
    check(cfgValid === 1'b0 && baseCfg === 7'h00, "sleep");
    deepSleep = 1'b0;
    wrap_up();
  end
endmodule
